// ==== include/aup_cfg.svh ====
// Register map, field layout and reset values of the underflow/priority block
`ifndef AUP_CFG_SVH
`define AUP_CFG_SVH

`define AUP_NSEQ        4
`define AUP_AW          12
`define AUP_DW          32
`define AUP_STRB_W      4
`define AUP_RANK_W      2
`define AUP_RANK_STRIDE 4
`define AUP_FLAG_BYTE   0
`define AUP_ADDR_UFLAG  12'h018
`define AUP_ADDR_PRIO   12'h020
`define AUP_ADDR_ISTAT  12'h030
`define AUP_ADDR_IMASK  12'h034
`define AUP_PRIO_RST    8'he4
`define AUP_FLAG_RST    4'h0
`define AUP_RESP_OKAY   2'h0
`define AUP_RESP_SLVERR 2'h2

`endif

// ==== include/aup_pkg.sv ====
// Types shared by the underflow/priority block
`include "aup_cfg.svh"
`default_nettype none

package aup_pkg;

    // Write channel states, one-hot
    typedef enum logic [1:0] {
        WS_IDLE = 2'b01,
        WS_RESP = 2'b10
    } aup_wst_t;

    // Read channel states, one-hot
    typedef enum logic [1:0] {
        RS_IDLE = 2'b01,
        RS_DATA = 2'b10
    } aup_rst_t;

    // Whole state of the top module
    typedef struct packed {
        aup_wst_t                                wst;
        aup_rst_t                                rst;
        logic                                    awready;
        logic                                    wready;
        logic                                    bvalid;
        logic [1:0]                              bresp;
        logic                                    arready;
        logic                                    rvalid;
        logic [1:0]                              rresp;
        logic [`AUP_DW-1:0]                      rdata;
        logic                                    have_aw;
        logic [`AUP_AW-1:0]                      waddr;
        logic                                    have_w;
        logic [`AUP_DW-1:0]                      wdata;
        logic [`AUP_STRB_W-1:0]                  wstrb;
        logic [`AUP_NSEQ-1:0]                    uflag;
        logic [`AUP_NSEQ*`AUP_RANK_W-1:0]        prio;
        logic [`AUP_NSEQ-1:0]                    ist;
        logic [`AUP_NSEQ-1:0]                    imask;
        logic                                    irq;
        logic [`AUP_NSEQ-1:0]                    pop;
        logic [`AUP_DW-1:0]                      rd_data;
        logic                                    rd_valid;
        logic [`AUP_NSEQ-1:0]                    grant;
        logic                                    grant_valid;
    } aup_state_t;

endpackage : aup_pkg

`default_nettype wire

// ==== design/aup_arbiter.sv ====
// Rank-ordered pick among pending sequencer triggers
`include "aup_cfg.svh"
`default_nettype none

module aup_arbiter (
    input  wire logic [`AUP_NSEQ-1:0]             pend,
    input  wire logic [`AUP_NSEQ*`AUP_RANK_W-1:0] ranks,
    output logic      [`AUP_NSEQ-1:0]             win
);

    // Sequencer i loses to any pending j of smaller rank value;
    // equal ranks fall back to the lower index so one still wins
    for (genvar i = 0; i < `AUP_NSEQ; i++)
    begin : g_seq
        logic [`AUP_NSEQ-1:0] beaten;
        for (genvar j = 0; j < `AUP_NSEQ; j++)
        begin : g_other
            if (j < i)
            begin : g_lo
                assign beaten[j] = pend[j] &&
                    (ranks[j*`AUP_RANK_W +: `AUP_RANK_W] <= ranks[i*`AUP_RANK_W +: `AUP_RANK_W]);
            end
            else if (j > i)
            begin : g_hi
                assign beaten[j] = pend[j] &&
                    (ranks[j*`AUP_RANK_W +: `AUP_RANK_W] < ranks[i*`AUP_RANK_W +: `AUP_RANK_W]);
            end
            else
            begin : g_self
                assign beaten[j] = 1'b0;
            end
        end
        assign win[i] = pend[i] && !(|beaten);
    end

endmodule : aup_arbiter

`default_nettype wire

// ==== design/aup_top.sv ====
// Underflow flags and sequencer priority registers behind an AXI4-Lite slave
//
// Notes on behaviour
// - Each of the four sequencers has a sticky underflow flag, set when its empty result FIFO is read.
// - A read of an empty FIFO moves no pointer and returns zero data.
// - Writing a one to an underflow flag clears it, and all flags are zero after reset.
// - Each sequencer has a 2-bit rank field at bits 13:12, 9:8, 5:4 and 1:0 for sequencers 3 to 0.
// - Rank value zero is the most urgent and three the least.
// - After reset each rank field equals its sequencer number.
// - Reserved bits read back as don't-care and software preserves them on writes.
// - Sequencers triggered together are run in rank order, most urgent first.
//
// Implementation choice: the AXI4-Lite slave port.
`include "aup_cfg.svh"
`default_nettype none

module aup_top (
    input  wire logic                             clk,
    input  wire logic                             nrst,
    // AXI4-Lite write address, data and response
    input  wire logic [`AUP_AW-1:0]               awaddr,
    input  wire logic                             awvalid,
    output logic                                  awready,
    input  wire logic [`AUP_DW-1:0]               wdata,
    input  wire logic [`AUP_STRB_W-1:0]           wstrb,
    input  wire logic                             wvalid,
    output logic                                  wready,
    output logic [1:0]                            bresp,
    output logic                                  bvalid,
    input  wire logic                             bready,
    // AXI4-Lite read
    input  wire logic [`AUP_AW-1:0]               araddr,
    input  wire logic                             arvalid,
    output logic                                  arready,
    output logic [`AUP_DW-1:0]                    rdata,
    output logic [1:0]                            rresp,
    output logic                                  rvalid,
    input  wire logic                             rready,
    // Sequencer FIFO read port
    input  wire logic [`AUP_NSEQ-1:0]             fifo_rd_req,
    input  wire logic [`AUP_NSEQ-1:0]             fifo_empty,
    input  wire logic [`AUP_NSEQ*`AUP_DW-1:0]     fifo_rd_data,
    output logic [`AUP_NSEQ-1:0]                  fifo_pop,
    output logic [`AUP_DW-1:0]                    rd_data,
    output logic                                  rd_valid,
    // Trigger arbitration and underflow interrupt
    input  wire logic [`AUP_NSEQ-1:0]             trig_pend,
    output logic [`AUP_NSEQ-1:0]                  grant,
    output logic                                  grant_valid,
    output logic                                  irq
);

    localparam logic [`AUP_AW-1:0] A_UFLAG = `AUP_ADDR_UFLAG;
    localparam logic [`AUP_AW-1:0] A_PRIO  = `AUP_ADDR_PRIO;
    localparam logic [`AUP_AW-1:0] A_ISTAT = `AUP_ADDR_ISTAT;
    localparam logic [`AUP_AW-1:0] A_IMASK = `AUP_ADDR_IMASK;

    aup_pkg::aup_state_t s_r;
    aup_pkg::aup_state_t s_nxt;

    logic                       aw_take;
    logic                       w_take;
    logic                       ar_take;
    logic                       got_aw;
    logic                       got_w;
    logic                       wr_fire;
    logic [`AUP_AW-1:0]         wa;
    logic [`AUP_DW-1:0]         wd;
    logic [`AUP_STRB_W-1:0]     ws;
    logic [`AUP_NSEQ-1:0]       uev;
    logic [`AUP_NSEQ-1:0]       arb_win;
    logic [`AUP_NSEQ-1:0]       flag_clr;

    // Handshakes; address and data may arrive in either order
    assign aw_take = s_r.awready && awvalid;
    assign w_take  = s_r.wready && wvalid;
    assign ar_take = s_r.arready && arvalid;
    assign got_aw  = s_r.have_aw || aw_take;
    assign got_w   = s_r.have_w || w_take;
    assign wr_fire = (s_r.wst == aup_pkg::WS_IDLE) && got_aw && got_w;
    assign wa      = s_r.have_aw ? s_r.waddr : awaddr;
    assign wd      = s_r.have_w ? s_r.wdata : wdata;
    assign ws      = s_r.have_w ? s_r.wstrb : wstrb;

    // Underflow events: a read request seen while that FIFO is empty
    assign uev = fifo_rd_req & fifo_empty;

    // Ones written into the flag byte, gated by its strobe
    assign flag_clr = ws[`AUP_FLAG_BYTE] ? wd[`AUP_NSEQ-1:0] : `AUP_FLAG_RST;

    aup_arbiter u_arb (
        .pend  (trig_pend),
        .ranks (s_r.prio),
        .win   (arb_win)
    );

    // Next state of the whole block
    always_comb
    begin
        logic found;
        s_nxt          = s_r;
        found          = 1'b0;
        s_nxt.pop      = '0;
        s_nxt.rd_data  = '0;
        s_nxt.rd_valid = 1'b0;

        // Latch whichever half of a write arrives first
        if (aw_take)
        begin
            s_nxt.have_aw = 1'b1;
            s_nxt.waddr   = awaddr;
        end
        if (w_take)
        begin
            s_nxt.have_w = 1'b1;
            s_nxt.wdata  = wdata;
            s_nxt.wstrb  = wstrb;
        end

        // Write channel
        unique case (s_r.wst)
            aup_pkg::WS_IDLE:
            begin
                if (wr_fire)
                begin
                    s_nxt.bresp = `AUP_RESP_OKAY;
                    if (wa[`AUP_AW-1:2] == A_UFLAG[`AUP_AW-1:2])
                    begin
                        s_nxt.uflag = s_r.uflag & ~flag_clr;
                    end
                    else if (wa[`AUP_AW-1:2] == A_PRIO[`AUP_AW-1:2])
                    begin
                        for (int i = 0; i < `AUP_NSEQ; i++)
                        begin
                            if (ws[(i*`AUP_RANK_STRIDE)/8])
                            begin
                                s_nxt.prio[i*`AUP_RANK_W +: `AUP_RANK_W] =
                                    wd[i*`AUP_RANK_STRIDE +: `AUP_RANK_W];
                            end
                        end
                    end
                    else if (wa[`AUP_AW-1:2] == A_IMASK[`AUP_AW-1:2])
                    begin
                        if (ws[`AUP_FLAG_BYTE])
                        begin
                            s_nxt.imask = wd[`AUP_NSEQ-1:0];
                        end
                    end
                    else if (wa[`AUP_AW-1:2] != A_ISTAT[`AUP_AW-1:2])
                    begin
                        s_nxt.bresp = `AUP_RESP_SLVERR;
                    end
                    s_nxt.have_aw = 1'b0;
                    s_nxt.have_w  = 1'b0;
                    s_nxt.bvalid  = 1'b1;
                    s_nxt.wst     = aup_pkg::WS_RESP;
                end
            end
            aup_pkg::WS_RESP:
            begin
                if (bready)
                begin
                    s_nxt.bvalid = 1'b0;
                    s_nxt.wst    = aup_pkg::WS_IDLE;
                end
            end
        endcase
        // Stall each half while its partner is outstanding
        s_nxt.awready = (s_nxt.wst == aup_pkg::WS_IDLE) && !s_nxt.have_aw;
        s_nxt.wready  = (s_nxt.wst == aup_pkg::WS_IDLE) && !s_nxt.have_w;

        // Read channel; reserved bits read as zero
        unique case (s_r.rst)
            aup_pkg::RS_IDLE:
            begin
                if (ar_take)
                begin
                    s_nxt.rdata = '0;
                    s_nxt.rresp = `AUP_RESP_OKAY;
                    if (araddr[`AUP_AW-1:2] == A_UFLAG[`AUP_AW-1:2])
                    begin
                        s_nxt.rdata[`AUP_NSEQ-1:0] = s_r.uflag;
                    end
                    else if (araddr[`AUP_AW-1:2] == A_PRIO[`AUP_AW-1:2])
                    begin
                        for (int i = 0; i < `AUP_NSEQ; i++)
                        begin
                            s_nxt.rdata[i*`AUP_RANK_STRIDE +: `AUP_RANK_W] =
                                s_r.prio[i*`AUP_RANK_W +: `AUP_RANK_W];
                        end
                    end
                    else if (araddr[`AUP_AW-1:2] == A_ISTAT[`AUP_AW-1:2])
                    begin
                        // Read clears; events of this cycle are re-applied below
                        s_nxt.rdata[`AUP_NSEQ-1:0] = s_r.ist;
                        s_nxt.ist                  = '0;
                    end
                    else if (araddr[`AUP_AW-1:2] == A_IMASK[`AUP_AW-1:2])
                    begin
                        s_nxt.rdata[`AUP_NSEQ-1:0] = s_r.imask;
                    end
                    else
                    begin
                        s_nxt.rresp = `AUP_RESP_SLVERR;
                    end
                    s_nxt.rvalid  = 1'b1;
                    s_nxt.arready = 1'b0;
                    s_nxt.rst     = aup_pkg::RS_DATA;
                end
            end
            aup_pkg::RS_DATA:
            begin
                if (rready)
                begin
                    s_nxt.rvalid  = 1'b0;
                    s_nxt.arready = 1'b1;
                    s_nxt.rst     = aup_pkg::RS_IDLE;
                end
            end
        endcase

        // Hardware sets last, so a set beats any clear of the same cycle
        s_nxt.uflag = s_nxt.uflag | uev;
        s_nxt.ist   = s_nxt.ist | uev;
        s_nxt.irq   = |(s_nxt.ist & s_nxt.imask);

        // FIFO read: lowest requester served; an empty one pops nothing
        for (int i = 0; i < `AUP_NSEQ; i++)
        begin
            if (fifo_rd_req[i] && !found)
            begin
                found          = 1'b1;
                s_nxt.rd_valid = 1'b1;
                if (!fifo_empty[i])
                begin
                    s_nxt.pop[i]  = 1'b1;
                    s_nxt.rd_data = fifo_rd_data[i*`AUP_DW +: `AUP_DW];
                end
            end
        end

        // Registered grant of the most urgent pending trigger
        s_nxt.grant       = arb_win;
        s_nxt.grant_valid = |trig_pend;
    end

    // State register; synchronous reset
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            s_r             <= '0;
            s_r.wst         <= aup_pkg::WS_IDLE;
            s_r.rst         <= aup_pkg::RS_IDLE;
            s_r.awready     <= 1'b1;
            s_r.wready      <= 1'b1;
            s_r.arready     <= 1'b1;
            s_r.uflag       <= `AUP_FLAG_RST;
            s_r.prio        <= `AUP_PRIO_RST;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from the state register
    assign awready     = s_r.awready;
    assign wready      = s_r.wready;
    assign bresp       = s_r.bresp;
    assign bvalid      = s_r.bvalid;
    assign arready     = s_r.arready;
    assign rdata       = s_r.rdata;
    assign rresp       = s_r.rresp;
    assign rvalid      = s_r.rvalid;
    assign fifo_pop    = s_r.pop;
    assign rd_data     = s_r.rd_data;
    assign rd_valid    = s_r.rd_valid;
    assign grant       = s_r.grant;
    assign grant_valid = s_r.grant_valid;
    assign irq         = s_r.irq;

    // Checks; helper finds a pending trigger more urgent than the winner
    logic                   better_pend;
    logic [`AUP_RANK_W-1:0] win_rank;
    always_comb
    begin
        better_pend = 1'b0;
        win_rank    = '0;
        for (int i = 0; i < `AUP_NSEQ; i++)
        begin
            if (arb_win[i])
            begin
                win_rank = s_r.prio[i*`AUP_RANK_W +: `AUP_RANK_W];
            end
        end
        for (int j = 0; j < `AUP_NSEQ; j++)
        begin
            if (trig_pend[j] && (s_r.prio[j*`AUP_RANK_W +: `AUP_RANK_W] < win_rank))
            begin
                better_pend = 1'b1;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence wr_taken_s;
        wr_fire;
    endsequence

    sequence resp_out_s;
        ##1 bvalid;
    endsequence

    flag_set_a:
    assert property ((|uev) |=> ((s_r.uflag & $past(uev)) == $past(uev)))
        else $error("underflow flag not set");

    empty_zero_a:
    assert property ((fifo_rd_req[0] && fifo_empty[0]) |=> (rd_valid && rd_data == '0 && !fifo_pop[0]))
        else $error("empty read popped or returned data");

    w1c_clear_a:
    assert property ((wr_fire && wa[`AUP_AW-1:2] == A_UFLAG[`AUP_AW-1:2] && uev == '0)
                     |=> ((s_r.uflag & $past(flag_clr)) == '0))
        else $error("written one did not clear flag");

    zero_keeps_a:
    assert property (wr_fire |=> (($past(s_r.uflag) & ~$past(flag_clr) & ~s_r.uflag) == '0))
        else $error("flag lost without a written one");

    prio_write_a:
    assert property ((wr_fire && wa[`AUP_AW-1:2] == A_PRIO[`AUP_AW-1:2] && ws == 4'hf)
                     |=> (s_r.prio == {$past(wd[13:12]), $past(wd[9:8]), $past(wd[5:4]), $past(wd[1:0])}))
        else $error("rank fields not written");

    rank_order_a:
    assert property (!better_pend)
        else $error("less urgent sequencer chosen");

    prio_reset_a:
    assert property ($rose(nrst) |-> (s_r.prio == `AUP_PRIO_RST && s_r.uflag == '0))
        else $error("reset values wrong");

    rsvd_zero_a:
    assert property ($rose(rvalid) |-> rdata[`AUP_DW-1:`AUP_NSEQ*`AUP_RANK_STRIDE] == '0)
        else $error("reserved bits not zero");

    grant_follow_a:
    assert property ((|trig_pend) |=> (grant_valid && $onehot(grant)))
        else $error("pending trigger not granted");

    wr_resp_a:
    assert property (wr_taken_s |-> resp_out_s)
        else $error("write response missing");

endmodule : aup_top

`default_nettype wire

// ==== verif/tb_top.sv ====
// Self-checking bench for the underflow flag and sequencer rank block
`include "aup_cfg.svh"
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic         clk;
    logic         nrst;
    logic [11:0]  awaddr;
    logic         awvalid;
    logic         awready;
    logic [31:0]  wdata;
    logic [3:0]   wstrb;
    logic         wvalid;
    logic         wready;
    logic [1:0]   bresp;
    logic         bvalid;
    logic         bready;
    logic [11:0]  araddr;
    logic         arvalid;
    logic         arready;
    logic [31:0]  rdata;
    logic [1:0]   rresp;
    logic         rvalid;
    logic         rready;
    logic [3:0]   fifo_rd_req;
    logic [3:0]   fifo_empty;
    logic [127:0] fifo_rd_data;
    logic [3:0]   fifo_pop;
    logic [31:0]  rd_data;
    logic         rd_valid;
    logic [3:0]   trig_pend;
    logic [3:0]   grant;
    logic         grant_valid;
    logic         irq;
    int           n_mismatch;
    int           n_checks;
    logic [31:0]  rv;
    logic [1:0]   rr;

    aup_top dut (
        .clk(clk), .nrst(nrst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .fifo_rd_req(fifo_rd_req),
        .fifo_empty(fifo_empty), .fifo_rd_data(fifo_rd_data), .fifo_pop(fifo_pop), .rd_data(rd_data),
        .rd_valid(rd_valid), .trig_pend(trig_pend), .grant(grant), .grant_valid(grant_valid), .irq(irq)
    );

    // Clock at 50 MHz
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Compare and count
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop

    // Write: address and data offered together, each dropped once taken
    task axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge clk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= s;
        wvalid <= 1'b1;
        bready <= 1'b1;
        r = 2'h3;
        while (n < 100 && r === 2'h3)
        begin
            @(posedge clk);
            n++;
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
            if (bvalid === 1'b1)
            begin
                r = bresp;
                bready <= 1'b0;
            end
        end
        // A response that never came counts against the run
        chk(32'(n < 100), 32'h1);
    endtask : axi_wr

    // Read: rready held high until rvalid is sampled
    task axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        r = 2'h3;
        while (n < 100 && r === 2'h3)
        begin
            @(posedge clk);
            n++;
            if (arvalid && arready)
                arvalid <= 1'b0;
            if (rvalid === 1'b1)
            begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
            end
        end
        // Read data that never came counts against the run
        chk(32'(n < 100), 32'h1);
    endtask : axi_rd

    // One-cycle FIFO read request; returns once the answer is settled
    task fifo_req(input logic [3:0] m, input logic [3:0] e);
        @(posedge clk);
        fifo_rd_req <= m;
        fifo_empty <= e;
        @(posedge clk);
        fifo_rd_req <= 4'h0;
        #1;
    endtask : fifo_req

    // Every pending pattern against the given rank fields, smaller value wins
    task arb_sweep(input logic [7:0] rk);
        int k;
        int i;
        int b;
        for (k = 0; k < 16; k++)
        begin
            b = -1;
            for (i = 0; i < 4; i++)
                if (k[i] && (b < 0 || rk[2*i +: 2] < rk[2*b +: 2]))
                    b = i;
            @(posedge clk);
            trig_pend <= 4'(k);
            @(posedge clk);
            #1;
            chk(32'(grant_valid), 32'(k != 0));
            chk(32'(grant), (b < 0) ? 32'h0 : 32'h1 << b);
        end
        @(posedge clk);
        trig_pend <= 4'h0;
    endtask : arb_sweep

    // Reset values, unmapped place, reset ranks
    task test_reset;
        axi_rd(`AUP_ADDR_PRIO, rv, rr);
        chk(rv, 32'h0000_3210);
        axi_rd(`AUP_ADDR_UFLAG, rv, rr);
        chk(rv, 32'h0);
        axi_rd(`AUP_ADDR_IMASK, rv, rr);
        chk(rv, 32'h0);
        axi_rd(12'h100, rv, rr);
        chk(32'(rr), 32'(`AUP_RESP_SLVERR));
        chk(rv, 32'h0);
        axi_wr(12'h100, 32'hffff_ffff, 4'hf, rr);
        chk(32'(rr), 32'(`AUP_RESP_SLVERR));
        arb_sweep(8'he4);
    endtask : test_reset

    // Empty reads give zero and no pop, full reads pop and pass data
    task test_underflow;
        int i;
        for (i = 0; i < 4; i++)
        begin
            fifo_req(4'h1 << i, 4'h1 << i);
            chk(32'(rd_valid), 32'h1);
            chk(rd_data, 32'h0);
            chk(32'(fifo_pop), 32'h0);
            axi_rd(`AUP_ADDR_UFLAG, rv, rr);
            chk(rv, 32'((4'h2 << i) - 4'h1));
            fifo_req(4'h1 << i, 4'h0);
            chk(32'(fifo_pop), 32'h1 << i);
            chk(rd_data, fifo_rd_data[32*i +: 32]);
        end
        axi_rd(`AUP_ADDR_ISTAT, rv, rr);
        chk(rv, 32'hf);
        axi_rd(`AUP_ADDR_ISTAT, rv, rr);
        chk(rv, 32'h0);
    endtask : test_underflow

    // Zero bits keep flags, one bits clear them, reserved bits kept at zero
    task test_w1c;
        axi_wr(`AUP_ADDR_UFLAG, 32'h0000_0000, 4'hf, rr);
        chk(32'(rr), 32'(`AUP_RESP_OKAY));
        axi_rd(`AUP_ADDR_UFLAG, rv, rr);
        chk(rv, 32'hf);
        axi_wr(`AUP_ADDR_UFLAG, 32'h5, 4'hf, rr);
        axi_rd(`AUP_ADDR_UFLAG, rv, rr);
        chk(rv, 32'ha);
        axi_wr(`AUP_ADDR_UFLAG, 32'ha, 4'hf, rr);
        axi_rd(`AUP_ADDR_UFLAG, rv, rr);
        chk(rv, 32'h0);
        // Set and clear of flag 0 at one edge; the set must win
        fork
            axi_wr(`AUP_ADDR_UFLAG, 32'h1, 4'hf, rr);
            fifo_req(4'h1, 4'h1);
        join
        axi_rd(`AUP_ADDR_UFLAG, rv, rr);
        chk(rv, 32'h1);
        axi_rd(`AUP_ADDR_ISTAT, rv, rr);
        chk(rv, 32'h1);
        axi_wr(`AUP_ADDR_UFLAG, 32'h1, 4'hf, rr);
        axi_rd(`AUP_ADDR_UFLAG, rv, rr);
        chk(rv, 32'h0);
    endtask : test_w1c

    // Rank fields: placement, reserved bits, byte strobes, new order
    task test_prio;
        axi_wr(`AUP_ADDR_PRIO, 32'h0000_0123, 4'hf, rr);
        axi_rd(`AUP_ADDR_PRIO, rv, rr);
        chk(rv, 32'h0000_0123);
        // Upper strobe alone must leave ranks 0 and 1 untouched
        axi_wr(`AUP_ADDR_PRIO, 32'h0000_1010, 4'h2, rr);
        axi_rd(`AUP_ADDR_PRIO, rv, rr);
        chk(rv, 32'h0000_1023);
        arb_sweep(8'h4b);
    endtask : test_prio

    // Masked and unmasked events, read-to-clear status
    task test_irq;
        axi_wr(`AUP_ADDR_IMASK, 32'h4, 4'hf, rr);
        axi_rd(`AUP_ADDR_IMASK, rv, rr);
        chk(rv, 32'h4);
        fifo_req(4'h2, 4'h2);
        repeat (2) @(posedge clk);
        #1;
        chk(32'(irq), 32'h0);
        // Two empty sequencers at once; both must be flagged
        fifo_req(4'hc, 4'hc);
        repeat (2) @(posedge clk);
        #1;
        chk(32'(irq), 32'h1);
        axi_rd(`AUP_ADDR_UFLAG, rv, rr);
        chk(rv, 32'he);
        axi_rd(`AUP_ADDR_ISTAT, rv, rr);
        chk(rv, 32'he);
        repeat (2) @(posedge clk);
        #1;
        chk(32'(irq), 32'h0);
    endtask : test_irq

    // Main sequence; all inputs defined at time zero
    initial
    begin
        n_mismatch = 0;
        n_checks = 0;
        nrst = 1'b0;
        {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
        {araddr, arvalid, rready, fifo_rd_req, fifo_empty, trig_pend} = '0;
        fifo_rd_data = 128'hd3d3_0003_c2c2_0002_b1b1_0001_a0a0_0000;
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        test_reset();
        test_underflow();
        test_w1c();
        test_prio();
        test_irq();
        report_and_stop();
    end

    // Watchdog well beyond the few hundred cycles the tests need
    initial
    begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        report_and_stop();
    end

endmodule : tb_top

`default_nettype wire
